/* inc/idba_params.svh */
`ifndef IDBA_PARAMS_SVH
`define IDBA_PARAMS_SVH
// frame and veto window lengths in clock cycles
`define IDBA_SHORT_LEN 6'd16
`define IDBA_LONG_LEN 6'd42
`define IDBA_VETO_LEN 6'd42
// destination word layout and table entry veto field
`define IDBA_HDR 2'b10
`define IDBA_B_CHAN 13
`define IDBA_B_FLUSH 12
`define IDBA_RSV 2'b00
`define IDBA_VETO_MSB 15
`define IDBA_VETO_LSB 10
// frame fields
`define IDBA_FMT_SHORT 2'b00
`define IDBA_FMT_LONG 2'b01
`define IDBA_STOP 1'b1
`define IDBA_LONG_PAD 16'h0000
`define IDBA_TRG_PAD 2'b00
`define IDBA_TRG_MARK 1'b1
// fixed control command codes
`define IDBA_CMD_CNTRST 8'h01
`define IDBA_CMD_COMBRST 8'h0e
`define IDBA_CMD_L0RST 8'h06
`define IDBA_CMD_CALA 8'h10
`define IDBA_CMD_CALB 8'h14
`define IDBA_CMD_CALC 8'h18
// serial link to the front-end
`define IDBA_SPI_BITS 5'd16
// register byte offsets
`define IDBA_OFS_CTRL 8'h00
`define IDBA_OFS_L1INT 8'h04
`define IDBA_OFS_HLTINT 8'h08
`define IDBA_OFS_RANGE 8'h0c
`define IDBA_OFS_INDEX 8'h10
`define IDBA_OFS_DATA 8'h14
`define IDBA_OFS_STAT 8'h18
`define IDBA_OFS_UCMD 8'h1c
// control and status bits
`define IDBA_C_ENB 0
`define IDBA_C_RST 1
`define IDBA_C_L1F 2
`define IDBA_C_HLTF 3
`define IDBA_S_FULL 0
`define IDBA_S_STICKY 1
`define IDBA_S_RPT_LSB 2
`define IDBA_S_RPT_MSB 8
`endif

/* inc/idba_pkg.sv */
package idba_pkg;
  typedef logic [31:0] idba_word_t;
  typedef enum logic [1:0] {FS_IDLE, FS_FETCH, FS_PUSH} idba_fsm_t;
endpackage

/* src/idba_top.sv */
`timescale 1ns/1ps
`include "idba_params.svh"
module idba_top #(
  parameter int QDEPTH = 16,
  parameter int QAW = 4
)(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input idba_pkg::idba_word_t HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input idba_pkg::idba_word_t HWDATA,
  input wire logic HREADY,
  output idba_pkg::idba_word_t HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic L0_ACCEPT,
  input wire logic L1_ACCEPT,
  input wire logic FLUSH_IN,
  input wire logic TRG_REQ,
  input wire logic [4:0] TRG_WORD,
  input wire logic [6:0] CMD_REQ,
  output logic TX_DATA,
  output logic TX_BUSY,
  output logic [8:0] ACK,
  output logic SPI_CS_N,
  output logic SPI_SCK,
  output logic SPI_MOSI
);
  import idba_pkg::*;
  localparam logic [QAW:0] Q_FULL = QDEPTH[QAW:0];

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_m_r, rst_n;
  always_ff @(posedge REF_CLK or negedge NRST)
    if (!NRST)
    begin
      rst_m_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m_r <= 1'b1;
      rst_n <= rst_m_r;
    end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic dp_wr_r;
  logic [7:0] dp_ofs_r;
  logic enable_r, blk_rst_r, l1f_r, hltf_r;
  logic [15:0] l1_int_r, hlt_int_r;
  logic [10:0] range_r;
  logic [9:0] idx_r, idx_w;
  logic [7:0] ucmd_r;
  logic [15:0] tbl [0:1023];
  logic q_full, sticky_r;
  logic [6:0] rpt_r;
  logic [31:0] rd_val;
  wire a_ok = HSEL && HTRANS[1] && HREADY;
  wire rd_go = a_ok && !HWRITE;
  wire wr_ctl = dp_wr_r && dp_ofs_r == `IDBA_OFS_CTRL;
  wire wr_stat = dp_wr_r && dp_ofs_r == `IDBA_OFS_STAT;

  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
    begin
      dp_wr_r <= 1'b0;
      dp_ofs_r <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
    else
    begin
      dp_wr_r <= a_ok && HWRITE;
      dp_ofs_r <= HADDR[7:0];
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end

  // index after any data-phase write, then read step
  always_comb
  begin
    idx_w = idx_r;
    if (dp_wr_r && dp_ofs_r == `IDBA_OFS_INDEX)
      idx_w = HWDATA[9:0];
    else if (dp_wr_r && dp_ofs_r == `IDBA_OFS_DATA)
      idx_w = idx_r + 10'h001;
  end

  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
      idx_r <= 10'h000;
    else if (rd_go && HADDR[7:0] == `IDBA_OFS_DATA)
      idx_r <= idx_w + 10'h001;
    else
      idx_r <= idx_w;

  always_ff @(posedge REF_CLK)
    if (dp_wr_r && dp_ofs_r == `IDBA_OFS_DATA)
      tbl[idx_r] <= HWDATA[15:0];

  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
    begin
      enable_r <= 1'b0;
      blk_rst_r <= 1'b0;
      l1f_r <= 1'b0;
      hltf_r <= 1'b0;
      l1_int_r <= 16'h0000;
      hlt_int_r <= 16'h0000;
      range_r <= 11'h000;
      ucmd_r <= 8'h00;
    end
    else
    begin
      blk_rst_r <= wr_ctl && HWDATA[`IDBA_C_RST];
      l1f_r <= wr_ctl && HWDATA[`IDBA_C_L1F];
      hltf_r <= wr_ctl && HWDATA[`IDBA_C_HLTF];
      if (wr_ctl)
        enable_r <= HWDATA[`IDBA_C_ENB];
      if (dp_wr_r && dp_ofs_r == `IDBA_OFS_L1INT)
        l1_int_r <= HWDATA[15:0];
      if (dp_wr_r && dp_ofs_r == `IDBA_OFS_HLTINT)
        hlt_int_r <= HWDATA[15:0];
      if (dp_wr_r && dp_ofs_r == `IDBA_OFS_RANGE)
        range_r <= HWDATA[10:0];
      if (dp_wr_r && dp_ofs_r == `IDBA_OFS_UCMD)
        ucmd_r <= HWDATA[7:0];
    end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (HADDR[7:0])
      `IDBA_OFS_CTRL: rd_val[`IDBA_C_ENB] = enable_r;
      `IDBA_OFS_L1INT: rd_val[15:0] = l1_int_r;
      `IDBA_OFS_HLTINT: rd_val[15:0] = hlt_int_r;
      `IDBA_OFS_RANGE: rd_val[10:0] = range_r;
      `IDBA_OFS_INDEX: rd_val[9:0] = idx_w;
      `IDBA_OFS_DATA: rd_val[15:0] = tbl[idx_w];
      `IDBA_OFS_STAT:
      begin
        rd_val[`IDBA_S_FULL] = q_full;
        rd_val[`IDBA_S_STICKY] = sticky_r;
        rd_val[`IDBA_S_RPT_MSB:`IDBA_S_RPT_LSB] = rpt_r;
      end
      `IDBA_OFS_UCMD: rd_val[7:0] = ucmd_r;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
      HRDATA <= 32'h0000_0000;
    else if (rd_go)
      HRDATA <= rd_val;

  // ****************************************************************
  // accept counters and flush requests
  // ****************************************************************
  idba_fsm_t st_r;
  logic [15:0] l0_cnt_r, l1_cnt_r;
  logic l1_fp_r, hlt_fp_r, chan_r, flush_r;
  wire l1_due = l1_int_r != 16'h0000 && l0_cnt_r >= l1_int_r;
  wire hlt_due = hlt_int_r != 16'h0000 && l1_cnt_r >= hlt_int_r;
  wire go = enable_r && st_r == FS_IDLE &&
            (l1_fp_r || hlt_fp_r || l1_due || hlt_due);
  wire go_hlt = !l1_fp_r && (hlt_fp_r || !l1_due);
  wire go_flush = l1_fp_r || hlt_fp_r;

  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
    begin
      l0_cnt_r <= 16'h0000;
      l1_cnt_r <= 16'h0000;
    end
    else if (blk_rst_r)
    begin
      l0_cnt_r <= 16'h0000;
      l1_cnt_r <= 16'h0000;
    end
    else if (go && go_flush)
    begin
      l0_cnt_r <= {15'h0000, L0_ACCEPT && enable_r};
      l1_cnt_r <= {15'h0000, L1_ACCEPT && enable_r};
    end
    else
    begin
      if (go && !go_hlt)
        l0_cnt_r <= {15'h0000, L0_ACCEPT && enable_r};
      else if (L0_ACCEPT && enable_r)
        l0_cnt_r <= l0_cnt_r + 16'h0001;
      if (go && go_hlt)
        l1_cnt_r <= {15'h0000, L1_ACCEPT && enable_r};
      else if (L1_ACCEPT && enable_r)
        l1_cnt_r <= l1_cnt_r + 16'h0001;
    end

  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
    begin
      l1_fp_r <= 1'b0;
      hlt_fp_r <= 1'b0;
    end
    else if (blk_rst_r)
    begin
      l1_fp_r <= 1'b0;
      hlt_fp_r <= 1'b0;
    end
    else
    begin
      l1_fp_r <= l1f_r || FLUSH_IN || (l1_fp_r && !(go && !go_hlt));
      hlt_fp_r <= hltf_r || FLUSH_IN || (hlt_fp_r && !(go && go_hlt));
    end

  // ****************************************************************
  // table walk and queue push
  // ****************************************************************
  logic [9:0] pos_r;
  logic [10:0] skip_r;
  logic [15:0] word_r;
  logic spi_act_r;
  wire [15:0] ent = tbl[pos_r];
  wire vetoed = |ent[`IDBA_VETO_MSB:`IDBA_VETO_LSB];
  wire [10:0] pos_inc = {1'b0, pos_r} + 11'h001;
  wire [9:0] pos_nxt = pos_inc >= range_r ? 10'h000 : pos_inc[9:0];
  wire push = st_r == FS_PUSH && !q_full && !spi_act_r;

  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
    begin
      st_r <= FS_IDLE;
      pos_r <= 10'h000;
      skip_r <= 11'h000;
      word_r <= 16'h0000;
      chan_r <= 1'b0;
      flush_r <= 1'b0;
    end
    else if (blk_rst_r)
    begin
      st_r <= FS_IDLE;
      pos_r <= 10'h000;
    end
    else
      unique case (st_r)
        FS_IDLE:
          if (go)
          begin
            st_r <= FS_FETCH;
            chan_r <= go_hlt;
            flush_r <= go_flush;
            skip_r <= 11'h000;
          end
        FS_FETCH:
        begin
          pos_r <= pos_nxt;
          if (!vetoed)
          begin
            word_r <= {`IDBA_HDR, chan_r, flush_r, `IDBA_RSV,
                       ent[9:0]};
            st_r <= FS_PUSH;
          end
          else if (skip_r + 11'h001 >= range_r)
            st_r <= FS_IDLE;
          else
            skip_r <= skip_r + 11'h001;
        end
        FS_PUSH:
          if (push)
            st_r <= FS_IDLE;
      endcase

  // ****************************************************************
  // destination queue
  // ****************************************************************
  logic [15:0] q_mem [0:QDEPTH-1];
  logic [QAW-1:0] wp_r, rp_r;
  logic [QAW:0] qcnt_r;
  logic pop;
  assign q_full = qcnt_r == Q_FULL;
  wire q_req = qcnt_r != '0;

  always_ff @(posedge REF_CLK)
    if (push)
      q_mem[wp_r] <= word_r;

  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
      qcnt_r <= '0;
    end
    else if (blk_rst_r)
    begin
      wp_r <= '0;
      rp_r <= '0;
      qcnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
      qcnt_r <= qcnt_r + {{QAW{1'b0}}, push} - {{QAW{1'b0}}, pop};
    end

  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
      sticky_r <= 1'b0;
    else
      sticky_r <= q_full || (sticky_r && !blk_rst_r &&
                  !(wr_stat && HWDATA[`IDBA_S_STICKY]));

  full_sticky_a: assert property (q_full |=> sticky_r)
    else $error("queue full not retained");

  // ****************************************************************
  // serial copy to the front-end
  // ****************************************************************
  logic [15:0] spi_sr_r;
  logic [4:0] spi_bit_r;
  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
    begin
      spi_act_r <= 1'b0;
      spi_sr_r <= 16'h0000;
      spi_bit_r <= 5'h00;
      SPI_CS_N <= 1'b1;
      SPI_SCK <= 1'b0;
      SPI_MOSI <= 1'b0;
    end
    else if (push)
    begin
      spi_act_r <= 1'b1;
      spi_sr_r <= word_r;
      spi_bit_r <= `IDBA_SPI_BITS;
      SPI_CS_N <= 1'b0;
      SPI_SCK <= 1'b0;
      SPI_MOSI <= word_r[15];
    end
    else if (spi_act_r)
    begin
      SPI_SCK <= !SPI_SCK;
      if (SPI_SCK)
      begin
        spi_sr_r <= spi_sr_r << 1;
        spi_bit_r <= spi_bit_r - 5'h01;
        SPI_MOSI <= spi_sr_r[14];
        if (spi_bit_r == 5'h01)
        begin
          spi_act_r <= 1'b0;
          SPI_CS_N <= 1'b1;
        end
      end
    end

  // ****************************************************************
  // broadcast arbiter and serialiser
  // ****************************************************************
  logic busy_r, cmd_pend_r, cmd_tx_r, long_r;
  logic [2:0] cmd_sel_r, win_i;
  logic [5:0] win_r, len_r;
  logic [41:0] sr_r;
  logic [7:0] cmd_code;
  logic any_req;

  function automatic logic [6:0] ham(input logic [31:0] d);
    logic [6:0] h;
    h = 7'h00;
    for (int k = 0; k < 32; k++)
      for (int j = 0; j < 7; j++)
        if ((((k + 1) >> j) & 1) == 1)
          h[j] = h[j] ^ d[k];
    return h;
  endfunction

  always_comb
  begin
    win_i = 3'd0;
    any_req = 1'b0;
    for (int i = 0; i < 7; i++)
      if (CMD_REQ[i])
      begin
        win_i = i[2:0];
        any_req = 1'b1;
      end
  end

  always_comb
  begin
    cmd_code = ucmd_r;
    unique case (cmd_sel_r)
      3'd6: cmd_code = `IDBA_CMD_CNTRST;
      3'd5: cmd_code = `IDBA_CMD_COMBRST;
      3'd4: cmd_code = `IDBA_CMD_L0RST;
      3'd3: cmd_code = `IDBA_CMD_CALA;
      3'd2: cmd_code = `IDBA_CMD_CALB;
      3'd1: cmd_code = `IDBA_CMD_CALC;
      default: cmd_code = ucmd_r;
    endcase
  end

  wire cmd_acc = any_req && !cmd_pend_r && !cmd_tx_r;
  wire cmd_go = cmd_pend_r && win_r == 6'd1;
  wire free = !busy_r && !cmd_pend_r && !cmd_acc;
  assign pop = free && q_req;
  wire trg_go = free && !q_req && TRG_REQ;
  wire [7:0] trg_code = {`IDBA_TRG_MARK, TRG_WORD, `IDBA_TRG_PAD};
  wire [7:0] sh_code = cmd_go ? cmd_code : trg_code;
  wire [31:0] lw = {q_mem[rp_r], `IDBA_LONG_PAD};
  wire [6:0] sh_ham = ham({24'h000000, sh_code});
  wire [15:0] sh_frm = {`IDBA_FMT_SHORT, sh_code, sh_ham[4:0], `IDBA_STOP};

  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
    begin
      cmd_pend_r <= 1'b0;
      cmd_sel_r <= 3'd0;
      win_r <= 6'd0;
    end
    else if (cmd_acc)
    begin
      cmd_pend_r <= 1'b1;
      cmd_sel_r <= win_i;
      win_r <= `IDBA_VETO_LEN;
    end
    else if (cmd_pend_r)
    begin
      win_r <= win_r - 6'd1;
      cmd_pend_r <= !cmd_go;
    end

  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
      rpt_r <= 7'h00;
    else
      for (int i = 0; i < 7; i++)
        if (CMD_REQ[i] && !(cmd_acc && win_i == i[2:0]))
          rpt_r[i] <= 1'b1;
        else if ((CMD_REQ[i] && cmd_acc) ||
                 (wr_stat && HWDATA[`IDBA_S_RPT_LSB + i]))
          rpt_r[i] <= 1'b0;

  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
    begin
      busy_r <= 1'b0;
      cmd_tx_r <= 1'b0;
      long_r <= 1'b0;
      len_r <= 6'd0;
      sr_r <= '1;
    end
    else if (cmd_go || trg_go)
    begin
      busy_r <= 1'b1;
      cmd_tx_r <= cmd_go;
      long_r <= 1'b0;
      len_r <= `IDBA_SHORT_LEN - 6'd1;
      sr_r <= {sh_frm, 26'h3ffffff};
    end
    else if (pop)
    begin
      busy_r <= 1'b1;
      long_r <= 1'b1;
      len_r <= `IDBA_LONG_LEN - 6'd1;
      sr_r <= {`IDBA_FMT_LONG, lw, ham(lw), `IDBA_STOP};
    end
    else if (busy_r)
    begin
      sr_r <= {sr_r[40:0], 1'b1};
      len_r <= len_r - 6'd1;
      busy_r <= len_r != 6'd0;
      cmd_tx_r <= cmd_tx_r && len_r != 6'd0;
    end

  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
    begin
      ACK <= 9'h000;
      TX_DATA <= 1'b1;
      TX_BUSY <= 1'b0;
    end
    else
    begin
      ACK <= {7'h00, pop, trg_go};
      if (cmd_acc)
        ACK[{1'b0, win_i} + 4'd2] <= 1'b1;
      TX_DATA <= sr_r[41];
      TX_BUSY <= busy_r;
    end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [5:0] run_h;
  logic [10:0] walk_h;
  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
      run_h <= 6'd0;
    else
      run_h <= busy_r ? run_h + 6'd1 : 6'd0;

  // cycles spent in the current table walk
  always_ff @(posedge REF_CLK or negedge rst_n)
    if (!rst_n)
      walk_h <= 11'h000;
    else
      walk_h <= st_r == FS_FETCH ? walk_h + 11'h001 : 11'h000;

  sequence s_fetch_any;
    st_r == FS_IDLE && go && !blk_rst_r;
  endsequence
  sequence s_fetched;
    st_r == FS_FETCH && !vetoed && !blk_rst_r;
  endsequence

  dest_header_a: assert property (push |-> word_r[15:14] == `IDBA_HDR)
    else $error("destination header wrong");
  flush_mark_a: assert property (s_fetch_any and go_flush |=>
    flush_r && l0_cnt_r <= 16'h0001)
    else $error("flush not marked or counters kept");
  fetch_at_once_a: assert property (s_fetch_any |=> st_r == FS_FETCH)
    else $error("fetch not started");
  wrap_pos_a: assert property ($past(st_r == FS_FETCH) &&
    range_r != 11'h000 && $stable(range_r) |-> {1'b0, pos_r} < range_r)
    else $error("position beyond range");
  frame_len_a: assert property ($fell(busy_r) |->
    run_h == (long_r ? `IDBA_LONG_LEN : `IDBA_SHORT_LEN))
    else $error("frame length wrong");
  veto_hold_a: assert property (cmd_acc |=>
    (!pop && !trg_go) [*8])
    else $error("broadcast started in veto window");
  dest_wait_a: assert property (q_req && !busy_r && !cmd_pend_r &&
    !any_req |=> busy_r && long_r)
    else $error("destination not sent when free");
  defer_rpt_a: assert property (cmd_pend_r && any_req |=>
    rpt_r != 7'h00)
    else $error("deferred command not flagged");
  ack_dest_a: assert property (pop |=> ACK[1] ##1 !ACK[1])
    else $error("destination acknowledge missing");
  spi_copy_a: assert property (push |=> !SPI_CS_N &&
    SPI_MOSI == $past(word_r[15]))
    else $error("serial copy not started");
  fetch_push_a: assert property (s_fetched |=> st_r == FS_PUSH)
    else $error("fetched entry not queued");
  walk_bound_a: assert property (st_r == FS_FETCH |->
    walk_h < range_r || walk_h == 11'h000)
    else $error("table walk beyond range");
endmodule

/* test/idba_fe_model.sv */
`timescale 1ns/1ps
// ****************
// front-end serial receiver
// ****************
module idba_fe_model (
  input wire logic clk,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  output logic [15:0] word_r,
  output int count_r
);
  logic sck_q;
  logic [15:0] sh_r;
  int nbit_r;
  initial
  begin
    sck_q = 1'b0;
    sh_r = '0;
    nbit_r = 0;
    word_r = '0;
    count_r = 0;
  end
  // shift msb first on sck rise, deliver any partial word but count only whole words
  always @(posedge clk)
  begin
    sck_q <= sck;
    if (cs_n === 1'b0 && sck === 1'b1 && sck_q === 1'b0)
    begin
      sh_r <= {sh_r[14:0], mosi};
      nbit_r <= nbit_r + 1;
    end
    else if (cs_n === 1'b1 && nbit_r != 0)
    begin
      word_r <= sh_r;
      if (nbit_r == 16)
        count_r <= count_r + 1;
      nbit_r <= 0;
    end
  end
endmodule

/* test/idba_top_bench.sv */
`timescale 1ns/1ps
`include "idba_params.svh"
module idba_top_bench;
  import idba_pkg::*;
  logic ref_clk = 0, nrst = 0, hsel = 0, hwrite = 0, l0_acc = 0, trg_req = 0;
  logic l1_acc = 0, flush_in = 0;
  logic [63:0] fr;
  logic [1:0] htrans = 0;
  logic [4:0] trg_word = 0;
  logic [6:0] cmd_req = 0;
  idba_word_t haddr = '0, hwdata = '0, hrdata, q;
  logic hreadyout, hresp, tx_data, tx_busy, cs_n, sck, mosi;
  logic [8:0] ack, acc, acc_pre;
  logic [15:0] fe_word;
  int fe_count, fails = 0, cmp_count = 0, n, c, c0;
  localparam logic [15:0] D0 = 16'h0155, D1 = 16'h06aa, D2 = 16'h00f3;
  idba_top dut (.REF_CLK(ref_clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .L0_ACCEPT(l0_acc), .L1_ACCEPT(l1_acc),
    .FLUSH_IN(flush_in),
    .TRG_REQ(trg_req), .TRG_WORD(trg_word), .CMD_REQ(cmd_req),
    .TX_DATA(tx_data), .TX_BUSY(tx_busy), .ACK(ack), .SPI_CS_N(cs_n),
    .SPI_SCK(sck), .SPI_MOSI(mosi));
  idba_fe_model fe (.clk(ref_clk), .cs_n(cs_n), .sck(sck), .mosi(mosi),
    .word_r(fe_word), .count_r(fe_count));
  // ****************
  // helpers
  // ****************
  initial
    forever #25 ref_clk = ~ref_clk;
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input idba_word_t d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic pulse_l0;
    l0_acc <= 1'b1;
    @(posedge ref_clk);
    l0_acc <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic frame;
    acc = '0;
    fr = '0;
    c = 0;
    n = 0;
    while (tx_busy !== 1'b1 && c < 400)
    begin
      @(posedge ref_clk);
      acc = acc | ack;
      fr = {fr[62:0], tx_data};
      c++;
    end
    acc_pre = acc;
    while (tx_busy === 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      acc = acc | ack;
      fr = {fr[62:0], tx_data};
      n++;
    end
    chk("frame wait", c < 400, 1);
  endtask
  task automatic wait_fe;
    c = 0;
    while (fe_count == c0 && c < 400)
    begin
      @(posedge ref_clk);
      c++;
    end
    chk("serial wait", c < 400, 1);
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    tally_and_finish;
  end
  // ****************
  // tests
  // ****************
  initial
  begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(0, `IDBA_OFS_STAT, 0);
    chk("stat", q, 0);
    bus(1, `IDBA_OFS_INDEX, 0);
    bus(1, `IDBA_OFS_DATA, D0);
    bus(1, `IDBA_OFS_DATA, D1);
    bus(1, `IDBA_OFS_DATA, D2);
    bus(0, `IDBA_OFS_INDEX, 0);
    chk("index", q, 3);
    bus(1, `IDBA_OFS_INDEX, 1);
    bus(0, `IDBA_OFS_DATA, 0);
    chk("data", q, D1);
    bus(0, `IDBA_OFS_INDEX, 0);
    chk("index", q, 2);
    bus(1, `IDBA_OFS_RANGE, 3);
    bus(1, `IDBA_OFS_L1INT, 2);
    bus(1, `IDBA_OFS_HLTINT, 0);
    bus(1, `IDBA_OFS_CTRL, 1);
    pulse_l0;
    c0 = fe_count;
    bus(1, `IDBA_OFS_CTRL, 5);
    frame;
    chk("dest len", n, 42);
    chk("dest ack", acc_pre, 9'h002);
    chk("dest frame", {fr[42:25], fr[1]},
      {2'b01, 16'h9000 | D0, 1'b1});
    wait_fe;
    chk("flush word", fe_word, 16'h9000 | D0);
    c0 = fe_count;
    pulse_l0;
    repeat (60) @(posedge ref_clk);
    chk("count cleared", fe_count, c0);
    pulse_l0;
    frame;
    wait_fe;
    chk("skip word", fe_word, 16'h8000 | D2);
    c0 = fe_count;
    bus(1, `IDBA_OFS_CTRL, 9);
    frame;
    wait_fe;
    chk("wrap word", fe_word, 16'hb000 | D0);
    trg_word <= 5'h15;
    cmd_req <= 7'h41;
    @(posedge ref_clk);
    cmd_req <= 7'h02;
    @(posedge ref_clk);
    chk("cmd ack", ack, 9'h100);
    cmd_req <= 7'h00;
    trg_req <= 1'b1;
    frame;
    chk("veto acks", acc_pre, 9'h000);
    chk("cmd len", n, 16);
    chk("cmd frame", {fr[16:7], fr[1]},
      {2'b00, `IDBA_CMD_CNTRST, 1'b1});
    c = 0;
    while (ack[0] !== 1'b1 && c < 100)
    begin
      @(posedge ref_clk);
      c++;
    end
    trg_req <= 1'b0;
    chk("trg ack", ack, 9'h001);
    frame;
    chk("trg len", n, 16);
    chk("trg frame", {fr[16:7], fr[1]},
      {2'b00, 1'b1, 5'h15, 2'b00, 1'b1});
    bus(0, `IDBA_OFS_STAT, 0);
    chk("repeat", q & 32'h1fc, 32'hc);
    bus(1, `IDBA_OFS_STAT, 32'h1fc);
    bus(0, `IDBA_OFS_STAT, 0);
    chk("repeat clr", q & 32'h1fc, 0);
    c0 = fe_count;
    bus(1, `IDBA_OFS_CTRL, 3);
    bus(1, `IDBA_OFS_CTRL, 5);
    frame;
    wait_fe;
    chk("reset walk", fe_word, 16'h9000 | D0);
    bus(1, `IDBA_OFS_HLTINT, 1);
    c0 = fe_count;
    l1_acc <= 1'b1;
    @(posedge ref_clk);
    l1_acc <= 1'b0;
    wait_fe;
    chk("filter word", fe_word, 16'ha000 | D2);
    c0 = fe_count;
    flush_in <= 1'b1;
    @(posedge ref_clk);
    flush_in <= 1'b0;
    wait_fe;
    chk("flush l1", fe_word, 16'h9000 | D0);
    c0 = fe_count;
    wait_fe;
    chk("flush filter", fe_word, 16'hb000 | D2);
    bus(1, `IDBA_OFS_CTRL, 0);
    c0 = fe_count;
    pulse_l0;
    pulse_l0;
    repeat (60) @(posedge ref_clk);
    chk("disabled", fe_count, c0);
    tally_and_finish;
  end
endmodule
